// *** lked_map.svh ***
`ifndef LKED_MAP_SVH
`define LKED_MAP_SVH

// ****************************************************************
// descriptor kind codes and register map
// ****************************************************************
`define LKED_TAG_SCHED      8'ha1
`define LKED_TAG_ECHO       8'ha2
`define LKED_ADDR_CTRL      8'h00
`define LKED_ADDR_SFC       8'h04
`define LKED_ADDR_ACTIVE    8'h08
`define LKED_ADDR_ECHO      8'h0c
`define LKED_ADDR_START     8'h10
`define LKED_ADDR_INTERVAL  8'h14
`define LKED_ADDR_STATUS    8'h18
`define LKED_ADDR_TAGS      8'h1c
`define LKED_CTRL_ENABLE    0
`define LKED_CTRL_RESTART   1
`define LKED_RST_CTRL       8'h01
`define LKED_MAX_ENTRIES    256
`define LKED_FIFO_DEPTH     32

`endif

// *** lked_pkg.sv ***
package lked_pkg;
    typedef enum logic [2:0] {
        LKED_KIND, LKED_LEN, LKED_BODY, LKED_SKIP
    } lked_state_t;
    typedef logic [15:0] lked_word_t;
endpackage

// *** lked_fifo_if.sv ***
`timescale 1ns/1ps
// ****************************************************************
// byte stream carrier between fifo and parser
// ****************************************************************
interface lked_fifo_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// *** lked_fifo.sv ***
`timescale 1ns/1ps
module lked_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    lked_fifo_if.src              out_if
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer arithmetic; count kept separately for honest full/empty
    always_comb begin
        push   = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
        pop    = out_if.ready && (cnt_q != '0);
        wr_d   = push ? wr_q + 1'b1 : wr_q;
        rd_d   = pop ? rd_q + 1'b1 : rd_q;
        cnt_d  = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only the pointers matter
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end

    assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign out_if.valid = (cnt_q != '0);
    assign out_if.data  = mem[rd_q];
endmodule

// *** lked_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - the 8-bit kind code selects the schedule or echo decoder.
// - the 8-bit byte count after the kind marks where it ends.
// - a 16-bit start count gives when the first entry is active.
// - a 16-bit interval separates activation of later entries.
// - the 8-bit entry count is entries minus one, zero means one.
// - entries are in time order, position k maps to time k.
// - each entry is a 16-bit unsigned value, msb first.
// - reserved bits before a field are dropped from its value.
// - the 16-bit echo word is captured and returned unchanged.
// - superframe counts compare modulo 65536.
`include "lked_map.svh"
module lked_top (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        BYTE_VALID_IN,
    input  wire logic [7:0]  BYTE_DATA_IN,
    input  wire logic        MSG_START_IN,
    output logic             BYTE_READY_OUT,
    input  wire logic        SF_TICK_IN,
    input  wire logic [15:0] SF_COUNT_IN,
    output lked_pkg::lked_word_t ACTIVE_CODE_OUT,
    output logic             ACTIVE_VALID_OUT,
    output lked_pkg::lked_word_t ECHO_WORD_OUT,
    output logic             ECHO_VALID_OUT,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP
);
    import lked_pkg::*;

    // ****************************************************************
    // input fifo
    // ****************************************************************
    lked_fifo_if fifo_bus ();
    logic fifo_ready;

    lked_fifo #(.WIDTH(8), .DEPTH(`LKED_FIFO_DEPTH)) u_fifo (
        .clk_in      (CLK_SYS_IN),
        .rstn_in     (RSTN_IN),
        .in_valid_in (BYTE_VALID_IN),
        .in_ready_out(fifo_ready),
        .in_data_in  (BYTE_DATA_IN),
        .out_if      (fifo_bus)
    );

    // ****************************************************************
    // parser state
    // ****************************************************************
    lked_word_t       sched_mem [`LKED_MAX_ENTRIES];
    lked_state_t      st_q, st_d;
    logic [7:0]       kind_q, kind_d, left_q, left_d, pos_q, pos_d;
    logic [7:0]       hi_q, hi_d, cnt_q, cnt_d;
    lked_word_t       start_q, start_d, intv_q, intv_d;
    lked_word_t       echo_q, echo_d;
    logic             echo_v_q, echo_v_d;
    logic             sched_v_q, sched_v_d;
    logic [8:0]       nent_q, nent_d;
    logic             wr_en;
    logic [7:0]       wr_idx;
    lked_word_t       wr_val;
    logic [7:0]       ctrl_q, ctrl_d;
    logic             take;
    logic [7:0]       b;

    // pull a byte whenever one waits; the parser never stalls itself
    assign take = fifo_bus.valid;
    assign fifo_bus.ready = 1'b1;
    assign b = fifo_bus.data;

    // byte-serial decode; msb byte arrives first in every 16-bit field
    always_comb begin
        st_d      = st_q;
        kind_d    = kind_q;
        left_d    = left_q;
        pos_d     = pos_q;
        hi_d      = hi_q;
        cnt_d     = cnt_q;
        start_d   = start_q;
        intv_d    = intv_q;
        echo_d    = echo_q;
        echo_v_d  = echo_v_q;
        sched_v_d = sched_v_q;
        nent_d    = nent_q;
        wr_en     = 1'b0;
        wr_idx    = '0;
        wr_val    = '0;
        if (MSG_START_IN) begin
            st_d = LKED_KIND;
        end else if (take) begin
            unique case (st_q)
                LKED_KIND: begin
                    kind_d = b;
                    st_d   = LKED_LEN;
                end
                LKED_LEN: begin
                    left_d = b;
                    pos_d  = '0;
                    if (b == 8'h00) begin
                        st_d = LKED_KIND;
                    end else if (kind_q == `LKED_TAG_SCHED ||
                                 kind_q == `LKED_TAG_ECHO) begin
                        st_d = LKED_BODY;
                    end else begin
                        st_d = LKED_SKIP;
                    end
                end
                LKED_BODY: begin
                    left_d = left_q - 8'h01;
                    pos_d  = pos_q + 8'h01;
                    // msb byte sits at even offsets up to the count byte,
                    // then at odd offsets once the list opens at byte 5;
                    // no reserved bits precede these fields
                    if ((pos_q[0] == 1'b0 && pos_q < 8'h04) ||
                        (pos_q[0] == 1'b1 && pos_q > 8'h04)) begin
                        hi_d = b;
                    end
                    if (kind_q == `LKED_TAG_ECHO) begin
                        if (pos_q == 8'h01) begin
                            echo_d   = {hi_q, b};
                            echo_v_d = 1'b1;
                        end
                    end else begin
                        unique case (pos_q)
                            8'h01: start_d = {hi_q, b};
                            8'h03: intv_d  = {hi_q, b};
                            8'h04: begin
                                cnt_d     = b;
                                nent_d    = {1'b0, b} + 9'd1;
                                sched_v_d = 1'b0;
                            end
                            default: begin
                                // entries start at byte 5, two bytes each
                                if (pos_q >= 8'h06 && pos_q[0] == 1'b0) begin
                                    wr_en  = 1'b1;
                                    wr_idx = 8'((pos_q - 8'h06) >> 1);
                                    wr_val = {hi_q, b};
                                    if (wr_idx == cnt_q) begin
                                        sched_v_d = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                    if (left_q == 8'h01) begin
                        st_d = LKED_KIND;
                    end
                end
                LKED_SKIP: begin
                    left_d = left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        st_d = LKED_KIND;
                    end
                end
                default: st_d = LKED_KIND;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_q      <= LKED_KIND;
            kind_q    <= '0;
            left_q    <= '0;
            pos_q     <= '0;
            hi_q      <= '0;
            cnt_q     <= '0;
            start_q   <= '0;
            intv_q    <= '0;
            echo_q    <= '0;
            echo_v_q  <= 1'b0;
            sched_v_q <= 1'b0;
            nent_q    <= '0;
        end else begin
            st_q      <= st_d;
            kind_q    <= kind_d;
            left_q    <= left_d;
            pos_q     <= pos_d;
            hi_q      <= hi_d;
            cnt_q     <= cnt_d;
            start_q   <= start_d;
            intv_q    <= intv_d;
            echo_q    <= echo_d;
            echo_v_q  <= echo_v_d;
            sched_v_q <= sched_v_d;
            nent_q    <= nent_d;
        end
    end

    // schedule table has no reset; sched_v_q guards its use
    always_ff @(posedge CLK_SYS_IN) begin
        if (wr_en) begin
            sched_mem[wr_idx] <= wr_val;
        end
    end

    // ****************************************************************
    // activation tracking
    // ****************************************************************
    logic [8:0]  act_k_q, act_k_d;
    lked_word_t  due_q, due_d, code_q, code_d;
    logic        code_v_q, code_v_d;

    // 16-bit sums wrap by construction, giving modulo 65536 compares
    function automatic lked_word_t lked_add(lked_word_t a, lked_word_t c);
        return a + c;
    endfunction

    always_comb begin
        act_k_d  = act_k_q;
        due_d    = due_q;
        code_d   = code_q;
        code_v_d = code_v_q;
        if (take && st_q == LKED_BODY && kind_q == `LKED_TAG_SCHED &&
            pos_q == 8'h04) begin
            act_k_d = '0;                     // new list restarts at k=0
            due_d   = start_q;
        end else if (sched_v_q && ctrl_q[`LKED_CTRL_ENABLE] && SF_TICK_IN &&
                     act_k_q < nent_q && SF_COUNT_IN == due_q) begin
            code_d   = sched_mem[act_k_q[7:0]];
            code_v_d = 1'b1;
            act_k_d  = act_k_q + 9'd1;
            due_d    = lked_add(due_q, intv_q);
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            act_k_q  <= '0;
            due_q    <= '0;
            code_q   <= '0;
            code_v_q <= 1'b0;
        end else begin
            act_k_q  <= act_k_d;
            due_q    <= due_d;
            code_q   <= code_d;
            code_v_q <= code_v_d;
        end
    end

    // ****************************************************************
    // ahb-lite slave, zero wait states, always okay
    // ****************************************************************
    logic        ap_v_q, ap_v_d, ap_w_q, ap_w_d;
    logic [7:0]  ap_a_q, ap_a_d;
    logic [31:0] rd_d, rd_q;

    function automatic logic [31:0] lked_rd(logic [7:0] a);
        unique case (a)
            `LKED_ADDR_CTRL:     return {24'h0, ctrl_q};
            `LKED_ADDR_SFC:      return {16'h0, SF_COUNT_IN};
            `LKED_ADDR_ACTIVE:   return {15'h0, code_v_q, code_q};
            `LKED_ADDR_ECHO:     return {15'h0, echo_v_q, echo_q};
            `LKED_ADDR_START:    return {16'h0, start_q};
            `LKED_ADDR_INTERVAL: return {16'h0, intv_q};
            `LKED_ADDR_STATUS:   return {15'h0, sched_v_q, 7'h0, act_k_q};
            `LKED_ADDR_TAGS:     return {16'h0, `LKED_TAG_ECHO,
                                         `LKED_TAG_SCHED};
            default:             return 32'h0;
        endcase
    endfunction

    always_comb begin
        ap_v_d = HSEL && HREADY && HTRANS[1];
        ap_w_d = HWRITE;
        ap_a_d = HADDR[7:0];
        ctrl_d = ctrl_q;
        rd_d   = rd_q;
        if (ap_v_q && ap_w_q && ap_a_q == `LKED_ADDR_CTRL) begin
            ctrl_d = HWDATA[7:0];
        end
        if (ap_v_d && !HWRITE) begin
            rd_d = lked_rd(HADDR[7:0]);
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ap_v_q <= 1'b0;
            ap_w_q <= 1'b0;
            ap_a_q <= '0;
            ctrl_q <= `LKED_RST_CTRL;
            rd_q   <= '0;
        end else begin
            ap_v_q <= ap_v_d;
            ap_w_q <= ap_w_d;
            ap_a_q <= ap_a_d;
            ctrl_q <= ctrl_d;
            rd_q   <= rd_d;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            BYTE_READY_OUT   <= 1'b0;
            ACTIVE_CODE_OUT  <= '0;
            ACTIVE_VALID_OUT <= 1'b0;
            ECHO_WORD_OUT    <= '0;
            ECHO_VALID_OUT   <= 1'b0;
            HREADYOUT        <= 1'b1;
            HRESP            <= 1'b0;
            HRDATA           <= '0;
        end else begin
            // ready lags by one cycle; fifo refuses when full anyway
            BYTE_READY_OUT   <= fifo_ready;
            ACTIVE_CODE_OUT  <= code_d;
            ACTIVE_VALID_OUT <= code_v_d;
            ECHO_WORD_OUT    <= echo_d;
            ECHO_VALID_OUT   <= echo_v_d;
            HREADYOUT        <= 1'b1;
            HRESP            <= 1'b0;
            HRDATA           <= rd_d;
        end
    end
endmodule

// *** lked_top_props.sv ***
`timescale 1ns/1ps
// ****************************************************************
// port checks for the descriptor parser
// ****************************************************************
module lked_top_props (
    input wire logic                 CLK_SYS_IN,
    input wire logic                 RSTN_IN,
    input wire logic                 SF_TICK_IN,
    input wire lked_pkg::lked_word_t ACTIVE_CODE_OUT,
    input wire logic                 ACTIVE_VALID_OUT,
    input wire lked_pkg::lked_word_t ECHO_WORD_OUT,
    input wire logic                 ECHO_VALID_OUT,
    input wire logic                 HSEL,
    input wire logic [31:0]          HADDR,
    input wire logic [1:0]           HTRANS,
    input wire logic                 HWRITE,
    input wire logic                 HREADY,
    input wire logic [31:0]          HRDATA,
    input wire logic                 HREADYOUT,
    input wire logic                 HRESP
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);
    // read taken at an address phase
    wire rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;

    chk_bus_ready: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    chk_bus_okay: assert property (!HRESP)
        else $error("slave gave an error response");
    chk_rdata_stands: assert property ($changed(HRDATA) |-> $past(rd_take))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property
        (rd_take && HADDR[7:0] == 8'h40 |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_echo_held: assert property (ECHO_VALID_OUT |=> ECHO_VALID_OUT)
        else $error("echo valid dropped");
    chk_echo_valid: assert property ($changed(ECHO_WORD_OUT) |-> ECHO_VALID_OUT)
        else $error("echo word moved without valid");
    // a new code only follows a superframe tick by one to three cycles
    chk_code_on_tick: assert property ($changed(ACTIVE_CODE_OUT) && ACTIVE_VALID_OUT
        |-> $past(SF_TICK_IN) || $past(SF_TICK_IN, 2) || $past(SF_TICK_IN, 3))
        else $error("active code moved without a tick");
    chk_valid_on_tick: assert property ($rose(ACTIVE_VALID_OUT)
        |-> $past(SF_TICK_IN) || $past(SF_TICK_IN, 2) || $past(SF_TICK_IN, 3))
        else $error("active valid rose without a tick");

    cover property ($rose(ECHO_VALID_OUT));
    cover property ($rose(ACTIVE_VALID_OUT));
    cover property (rd_take ##2 rd_take);
endmodule

bind lked_top lked_top_props lked_top_props_inst (.CLK_SYS_IN, .RSTN_IN,
    .SF_TICK_IN, .ACTIVE_CODE_OUT, .ACTIVE_VALID_OUT, .ECHO_WORD_OUT,
    .ECHO_VALID_OUT, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA,
    .HREADYOUT, .HRESP);

// *** lked_ncc_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// control centre side: sends descriptor bytes into the parser
// ****************************************************************
module lked_ncc_model (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output logic [7:0]      data_out,
    output logic            start_out
);
    initial begin
        valid_out = 1'b0;
        data_out  = 8'h00;
        start_out = 1'b0;
    end
    // one terminal-keyed message, bytes held until room is seen
    // no reserved bits in these fields, so none to randomise
    task automatic msg(input logic [7:0] q[$]);
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
        foreach (q[i]) begin
            valid_out <= 1'b1;
            data_out  <= q[i];
            @(posedge clk_in);
            while (ready_in !== 1'b1) @(posedge clk_in);
        end
        valid_out <= 1'b0;
        // idle line shows the inverse so a stale byte never looks valid
        data_out  <= ~q[q.size()-1];
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import lked_pkg::*;
    logic        clk;
    logic        rstn;
    logic        rdy;
    logic        vld;
    logic [7:0]  dat;
    logic        st;
    logic        sf_tick;
    logic [15:0] sf_count;
    lked_word_t  act_code;
    lked_word_t  echo_word;
    logic        act_valid;
    logic        echo_valid;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic        hresp;
    int          error_cnt = 0;
    int          num_checks = 0;

    lked_top lked_top_inst (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
        .BYTE_VALID_IN(vld), .BYTE_DATA_IN(dat), .MSG_START_IN(st),
        .BYTE_READY_OUT(rdy), .SF_TICK_IN(sf_tick), .SF_COUNT_IN(sf_count),
        .ACTIVE_CODE_OUT(act_code), .ACTIVE_VALID_OUT(act_valid),
        .ECHO_WORD_OUT(echo_word), .ECHO_VALID_OUT(echo_valid),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp));
    lked_ncc_model lked_ncc_model_inst (.clk_in(clk), .ready_in(rdy),
        .valid_out(vld), .data_out(dat), .start_out(st));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic tick(input logic [15:0] c, input logic v,
                        input logic [15:0] exp);
        @(posedge clk);
        sf_tick  <= 1'b1;
        sf_count <= c;
        @(posedge clk);
        sf_tick  <= 1'b0;
        repeat (4) @(posedge clk);
        check({15'h0, act_valid, act_code}, {15'h0, v, exp});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        sf_tick = 1'b0;
        sf_count = 16'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        ahb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        check({15'h0, act_valid, act_code}, 32'h0);
        check({15'h0, echo_valid, echo_word}, 32'h0);
        check({31'h0, rdy}, 32'h1);
        ahb(1'b1, 8'h40, 32'hdead_beef);
        ahb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        $display("test bus done");
        // a look-alike echo inside an unknown kind must be skipped
        lked_ncc_model_inst.msg('{8'ha2, 8'h02, 8'h9a, 8'hbc, 8'h55, 8'h04,
            8'ha2, 8'h02, 8'hde, 8'had});
        repeat (40) @(posedge clk);
        check({15'h0, echo_valid, echo_word},
              {15'h0, 1'b1, 16'h9abc});
        $display("test echo done");
        // three entries, start just below the wrap point
        lked_ncc_model_inst.msg('{8'ha1, 8'h0b, 8'hff, 8'hfe, 8'h00, 8'h03,
            8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
        repeat (40) @(posedge clk);
        ahb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0000_fffe);
        ahb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0000_0003);
        tick(16'hfffd, 1'b0, 16'h0);
        tick(16'hfffe, 1'b1, 16'h1122);
        tick(16'hffff, 1'b1, 16'h1122);
        tick(16'h0001, 1'b1, 16'h3344);
        tick(16'h0004, 1'b1, 16'h5566);
        $display("test schedule done");
        // zero count means one entry, then an echo proves the length
        lked_ncc_model_inst.msg('{8'ha1, 8'h07, 8'h00, 8'h10, 8'h00, 8'h01,
            8'h00, 8'hab, 8'hcd, 8'ha2, 8'h02, 8'h8e, 8'h01});
        repeat (40) @(posedge clk);
        check({15'h0, echo_valid, echo_word},
              {15'h0, 1'b1, 16'h8e01});
        tick(16'h0010, 1'b1, 16'habcd);
        tick(16'h0011, 1'b1, 16'habcd);
        $display("test single entry done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule
